/* File: rtl/rsl_link.sv */
// Module: RS485 slave link with ASCII framing, LRC check and AXI4-Lite registers
// Overview of operation
// - 9600 baud, seven data, no parity, two stop
// - Half duplex: drive line only while sending
// - Transmit only as a reply to commands
// - LRC over message content detects corruption
// - Serial mode only while switch seven on
// - Serial mode ignores panel and terminal runs
// - Address from switches one-six, one is MSB
// - Switch seven off stores current address
// - Parameter reset keeps stored address
// - New address taken only at power-up
// - All switches off gives default configuration
// - Colon starts message, CR LF ends it
// - Reply only after whole message received
`timescale 1ns/100ps
module rsl_link
	import rsl_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        por_done,
	input  wire logic        param_reset,
	input  wire logic [6:0]  dip_sw,
	input  wire logic        panel_run,
	input  wire logic        term_run,
	output logic             run_cmd,
	output logic             serial_mode,
	input  wire logic        line_rx,
	output logic             line_tx,
	output logic             line_oe,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rsl_rx_e;
	typedef enum {MS_HUNT, MS_BODY, MS_LF, MS_HOLD} rsl_msg_e;
	typedef enum {TX_IDLE, TX_GAP, TX_START, TX_DATA, TX_STOP, TX_DONE} rsl_tx_e;

	rsl_fifo_if tx_in ();   // Software to FIFO
	rsl_fifo_if tx_out ();  // FIFO to serialiser

	rsl_fifo u_fifo (
		.aclk    (aclk),
		.aresetn (aresetn),
		.in_s    (tx_in.snk),
		.out_s   (tx_out.src)
	);

	// Station address and mode
	logic [5:0]  stored_addr_r;  // Address kept across parameter resets
	logic [5:0]  live_addr_r;    // Address used for matching
	logic        sw7_d_r;        // Previous switch 7 level
	logic        por_seen_r;     // Power-up capture done
	wire  [5:0]  sw_addr = dip_sw[5:0];  // Switch 1 is bit 5, switch 6 bit 0
	wire         sw7     = dip_sw[6];    // Off is the shipping default

	// Address caught once after release of power-up if switch seven is on, not on later changes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stored_addr_r <= ADDR_RESET;
			live_addr_r   <= ADDR_RESET;
			sw7_d_r       <= 1'b0;
			por_seen_r    <= 1'b0;
		end else begin
			sw7_d_r <= sw7;
			if (por_done && !por_seen_r) begin
				por_seen_r <= 1'b1;
				if (sw7) live_addr_r <= sw_addr;
			end
			if (sw7_d_r && !sw7) stored_addr_r <= live_addr_r;
			// param_reset deliberately leaves both addresses alone
		end
	end

	assign serial_mode = sw7;
	logic ctrl_run_r;  // Run command written by software in serial mode
	assign run_cmd = serial_mode ? ctrl_run_r : (panel_run | term_run);

	// Receiver: start-stop framing with mid-bit sampling
	rsl_rx_e     rx_st_r;
	logic [15:0] rx_cnt_r;
	logic [2:0]  rx_bit_r;
	logic [6:0]  rx_sh_r;
	logic        rx_stb_r;  // One-cycle pulse per good character
	logic        tx_busy;
	wire         rx_in = tx_busy ? 1'b1 : line_rx;  // Own echo is ignored

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_st_r  <= RX_IDLE;
			rx_cnt_r <= '0;
			rx_bit_r <= '0;
			rx_sh_r  <= '0;
			rx_stb_r <= 1'b0;
		end else begin
			rx_stb_r <= 1'b0;
			unique case (rx_st_r)
				RX_IDLE: if (!rx_in) begin
					rx_st_r  <= RX_START;
					rx_cnt_r <= 16'(HALF_CYC);
				end
				RX_START: if (rx_cnt_r == '0) begin
					rx_st_r  <= rx_in ? RX_IDLE : RX_DATA;  // Glitch rejected
					rx_cnt_r <= 16'(BIT_CYC - 1);
					rx_bit_r <= '0;
				end else rx_cnt_r <= rx_cnt_r - 1'b1;
				RX_DATA: if (rx_cnt_r == '0) begin
					rx_sh_r  <= {rx_in, rx_sh_r[6:1]};  // LSB first
					rx_cnt_r <= 16'(BIT_CYC - 1);
					if (rx_bit_r == 3'(DATA_BITS - 1)) rx_st_r <= RX_STOP;
					rx_bit_r <= rx_bit_r + 1'b1;
				end else rx_cnt_r <= rx_cnt_r - 1'b1;
				RX_STOP: if (rx_cnt_r == '0) begin
					rx_st_r  <= RX_IDLE;
					rx_stb_r <= rx_in;  // Framing error drops the character
				end else rx_cnt_r <= rx_cnt_r - 1'b1;
			endcase
		end
	end

	// Message assembly: hex pairs after colon, LRC sums all bytes
	rsl_msg_e    ms_st_r;
	logic [6:0]  body [MAX_CHARS];  // Body characters of the most recent message, accepted or discarded
	logic [6:0]  ms_len_r;          // Characters in current body
	logic [6:0]  acc_len_r;         // Characters of accepted body
	logic [7:0]  lrc_r;             // Running byte sum
	logic [3:0]  hi_nib_r;          // Pending high nibble
	logic        odd_r;             // High nibble held
	logic [7:0]  b0_r;              // First byte: address
	logic [7:0]  b1_r;              // Second byte: command
	logic [7:0]  last_b_r;          // Last byte: the LRC itself
	logic [7:0]  acc_cmd_r;         // Command of accepted message
	logic        msg_ok_r;          // Pulse: message accepted
	logic [15:0] drop_cnt_r;        // Discarded messages
	wire         is_hex  = (rx_sh_r >= 7'h30 && rx_sh_r <= 7'h39) || (rx_sh_r >= 7'h41 && rx_sh_r <= 7'h46);
	wire  [3:0]  nib     = (rx_sh_r <= 7'h39) ? rx_sh_r[3:0] : 4'(rx_sh_r[3:0] + 4'h9);
	wire  [7:0]  new_b   = {hi_nib_r, nib};
	wire  [7:0]  sum_chk = lrc_r - last_b_r;            // Sum of content
	wire         lrc_ok  = (8'(sum_chk + last_b_r) == 8'h00);
	wire         adr_ok  = (b0_r[5:0] == live_addr_r) && (b0_r[7:6] == 2'h0);
	wire         cmd_ok  = (b1_r == CMD_READ) || (b1_r == CMD_WRITE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ms_st_r <= MS_HUNT;
			ms_len_r <= '0;
			acc_len_r <= '0;
			lrc_r <= '0;
			hi_nib_r <= '0;
			odd_r <= 1'b0;
			b0_r <= '0;
			b1_r <= '0;
			last_b_r <= '0;
			acc_cmd_r <= '0;
			msg_ok_r <= 1'b0;
			drop_cnt_r <= '0;
		end else begin
			msg_ok_r <= 1'b0;
			if (rx_stb_r && rx_sh_r == CH_COLON) begin  // Colon always restarts
				ms_st_r <= MS_BODY;
				ms_len_r <= '0;
				lrc_r <= '0;
				odd_r <= 1'b0;
			end else if (rx_stb_r) begin
				unique case (ms_st_r)
					MS_HUNT, MS_HOLD: ;  // Noise between messages ignored
					MS_BODY: if (rx_sh_r == CH_CR) ms_st_r <= MS_LF;
					else if (!is_hex || ms_len_r == 7'(MAX_CHARS)) begin
						ms_st_r <= MS_HUNT;
						drop_cnt_r <= drop_cnt_r + 1'b1;
					end else begin
						body[ms_len_r[5:0]] <= rx_sh_r;
						ms_len_r <= ms_len_r + 1'b1;
						odd_r <= !odd_r;
						hi_nib_r <= nib;
						if (odd_r) begin
							lrc_r <= lrc_r + new_b;
							last_b_r <= new_b;
							if (ms_len_r == 7'd1) b0_r <= new_b;
							if (ms_len_r == 7'd3) b1_r <= new_b;
						end
					end
					MS_LF: begin
						// Decide only after the full terminator
						if (rx_sh_r == CH_LF && !odd_r && ms_len_r >= 7'd6 && lrc_ok && adr_ok && cmd_ok
							&& serial_mode) begin
							msg_ok_r  <= 1'b1;
							acc_cmd_r <= b1_r;
							acc_len_r <= ms_len_r;
							ms_st_r   <= MS_HOLD;
						end else begin
							ms_st_r <= MS_HUNT;  // Silent discard
							drop_cnt_r <= drop_cnt_r + 1'b1;
						end
					end
				endcase
			end
		end
	end

	// Reply permission: granted by an accepted message, used by one reply
	logic reply_ok_r;
	logic tx_end;

	// Transmitter with quiet gap before driving the line
	rsl_tx_e     tx_st_r;
	logic [31:0] tx_cnt_r;
	logic [2:0]  tx_bit_r;
	logic [6:0]  tx_sh_r;
	logic        seen_lf_r;  // Reply ends after LF leaves
	assign tx_busy = (tx_st_r != TX_IDLE) && (tx_st_r != TX_GAP);
	wire  tx_pop = (tx_st_r == TX_IDLE || tx_st_r == TX_DONE) && tx_out.valid && reply_ok_r && !seen_lf_r
		&& (tx_st_r == TX_DONE || tx_cnt_r == '0);
	assign tx_out.ready = tx_pop;
	assign tx_end = (tx_st_r == TX_DONE) && seen_lf_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) reply_ok_r <= 1'b0;
		else if (msg_ok_r) reply_ok_r <= 1'b1;  // Only replies are sent
		else if (tx_end) reply_ok_r <= 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_st_r <= TX_IDLE;
			tx_cnt_r <= '0;
			tx_bit_r <= '0;
			tx_sh_r <= '0;
			seen_lf_r <= 1'b0;
			line_tx <= 1'b1;
			line_oe <= 1'b0;
		end else begin
			unique case (tx_st_r)
				TX_IDLE: begin
					line_oe <= 1'b0;
					seen_lf_r <= 1'b0;
					if (msg_ok_r) tx_cnt_r <= 32'(WAIT_CYC);  // Quiet after request
					else if (tx_cnt_r != '0) tx_cnt_r <= tx_cnt_r - 1'b1;
					if (tx_pop) begin
						tx_sh_r <= tx_out.data;
						tx_st_r <= TX_START;
						tx_cnt_r <= 32'(BIT_CYC - 1);
						line_oe <= 1'b1;  // Drive only while replying
						line_tx <= 1'b0;
					end
				end
				TX_START: if (tx_cnt_r == '0) begin
					tx_st_r <= TX_DATA;
					tx_bit_r <= '0;
					line_tx <= tx_sh_r[0];
					tx_cnt_r <= 32'(BIT_CYC - 1);
				end else tx_cnt_r <= tx_cnt_r - 1'b1;
				TX_DATA: if (tx_cnt_r == '0) begin
					tx_cnt_r <= 32'(BIT_CYC - 1);
					tx_bit_r <= tx_bit_r + 1'b1;
					if (tx_bit_r == 3'(DATA_BITS - 1)) begin
						tx_st_r <= TX_STOP;
						line_tx <= 1'b1;
						tx_cnt_r <= 32'(BIT_CYC * STOP_BITS - 1);  // Two stop bits
					end else line_tx <= tx_sh_r[tx_bit_r + 3'd1];
				end else tx_cnt_r <= tx_cnt_r - 1'b1;
				TX_STOP: if (tx_cnt_r == '0) begin
					tx_st_r <= TX_DONE;
					if (tx_sh_r == CH_LF) seen_lf_r <= 1'b1;
				end else tx_cnt_r <= tx_cnt_r - 1'b1;
				TX_DONE: if (tx_pop) begin
					tx_sh_r <= tx_out.data;
					tx_st_r <= TX_START;
					tx_cnt_r <= 32'(BIT_CYC - 1);
					line_tx <= 1'b0;
				end else if (tx_end || !tx_out.valid) begin
					tx_st_r <= TX_GAP;  // Release line, then quiet time
					line_oe <= 1'b0;
					tx_cnt_r <= 32'(WAIT_CYC);
				end
				TX_GAP: if (tx_cnt_r == '0) tx_st_r <= TX_IDLE;
					else tx_cnt_r <= tx_cnt_r - 1'b1;
			endcase
		end
	end

	// AXI4-Lite write channel: address and data in either order
	logic        aw_hold_r, w_hold_r;
	logic [7:0]  aw_r;
	logic [31:0] w_r;
	wire         wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
	wire         wr_map = (aw_r == REG_CTRL) || (aw_r == REG_TXDATA);
	assign s_axi_awready = !aw_hold_r;
	assign s_axi_wready  = !w_hold_r;
	assign tx_in.valid = wr_go && (aw_r == REG_TXDATA);
	assign tx_in.data  = w_r[6:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			aw_r <= '0;
			w_r <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			ctrl_run_r <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				aw_r <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				w_r <= s_axi_wdata;
			end
			if (param_reset) ctrl_run_r <= 1'b0;
			if (wr_go && !(aw_r == REG_TXDATA && !tx_in.ready)) begin  // Full FIFO stalls the write
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
				if (aw_r == REG_CTRL && s_axi_wstrb[0]) ctrl_run_r <= w_r[0];
			end
			if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
		end
	end

	// AXI4-Lite read channel
	wire  [7:0]  ar_a = {s_axi_araddr[7:2], 2'h0};
	logic [5:0]  rd_idx_r;  // Body read pointer
	wire  [31:0] rd_mux =
		(ar_a == REG_CTRL)   ? {31'h0, ctrl_run_r} :
		(ar_a == REG_STATUS) ? {8'h0, 3'h0, reply_ok_r, tx_busy, serial_mode, stored_addr_r,
		                        2'h0, live_addr_r, 4'h0} :
		(ar_a == REG_RXCMD)  ? {17'h0, acc_len_r, acc_cmd_r} :
		(ar_a == REG_RXBODY) ? {25'h0, body[rd_idx_r]} :
		(ar_a == REG_RXERR)  ? {16'h0, drop_cnt_r} : ZERO32;
	wire         rd_map = (ar_a == REG_CTRL) || (ar_a == REG_STATUS) || (ar_a == REG_RXCMD)
		|| (ar_a == REG_RXBODY) || (ar_a == REG_RXERR) || (ar_a == REG_TXDATA);
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= ZERO32;
			s_axi_rresp <= RESP_OKAY;
			rd_idx_r <= '0;
		end else begin
			if (msg_ok_r) rd_idx_r <= '0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
				if (ar_a == REG_RXBODY) rd_idx_r <= rd_idx_r + 1'b1;  // Read advances the pointer
			end else if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
		end
	end
endmodule // rsl_link

/* File: rtl/rsl_pkg.sv */
// Package: constants for the serial slave link of the drive
package rsl_pkg;
	localparam int          CLK_HZ         = 20000000;   // System clock rate
	localparam int          BAUD           = 9600;       // Line bit rate
	localparam int          BIT_CYC        = CLK_HZ / BAUD;          // Cycles per bit, rounded down
	localparam int          HALF_CYC       = BIT_CYC / 2;            // Mid-bit sample point
	localparam int          DATA_BITS      = 7;          // Data bits per character
	localparam int          STOP_BITS      = 2;          // Stop bits per character
	localparam int          WAIT_MS        = 10;         // Quiet time around an exchange, ms
	localparam int          WAIT_CYC       = (CLK_HZ / 1000) * WAIT_MS;  // Quiet time in cycles
	localparam logic [6:0]  CH_COLON       = 7'h3A;      // Message start
	localparam logic [6:0]  CH_CR          = 7'h0D;      // First terminator
	localparam logic [6:0]  CH_LF          = 7'h0A;      // Second terminator
	localparam logic [7:0]  CMD_READ       = 8'h03;      // Read data command
	localparam logic [7:0]  CMD_WRITE      = 8'h06;      // Write data command
	localparam int          MAX_CHARS      = 64;         // Body characters held per message
	localparam int          FIFO_DEPTH     = 4;          // Transmit FIFO depth
	localparam int          FIFO_WIDTH     = 7;          // Transmit FIFO width
	// Register map (byte addresses)
	localparam logic [7:0]  REG_CTRL       = 8'h00;      // Control: bit0 serial run command
	localparam logic [7:0]  REG_STATUS     = 8'h04;      // Status: mode, busy flags, addresses
	localparam logic [7:0]  REG_RXCMD      = 8'h08;      // Last accepted command byte
	localparam logic [7:0]  REG_RXBODY     = 8'h0C;      // Body character read port
	localparam logic [7:0]  REG_TXDATA     = 8'h10;      // Reply character write port
	localparam logic [7:0]  REG_RXERR      = 8'h14;      // Discarded message count
	localparam logic [1:0]  RESP_OKAY      = 2'h0;       // AXI OKAY
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;       // AXI SLVERR for unmapped
	localparam logic [5:0]  ADDR_RESET     = 6'h00;      // Stored address after power-up
	localparam logic [31:0] ZERO32         = 32'h0000_0000;  // Zero word
endpackage

/* File: rtl/rsl_fifo_if.sv */
// Interface: valid/ready stream between link and transmit FIFO
`timescale 1ns/100ps
interface rsl_fifo_if;
	logic       valid;  // Item offered
	logic       ready;  // Item accepted
	logic [6:0] data;   // Character
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

/* File: rtl/rsl_fifo.sv */
// Module: small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module rsl_fifo
	import rsl_pkg::*;
#(
	parameter int WIDTH = FIFO_WIDTH,  // Word width
	parameter int DEPTH = FIFO_DEPTH   // Word count, power of two
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	rsl_fifo_if.snk   in_s,
	rsl_fifo_if.src   out_s
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];  // Storage
	logic [AW:0]      wp_r;         // Write pointer with wrap bit
	logic [AW:0]      rp_r;         // Read pointer with wrap bit
	wire              full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	wire              empty = (wp_r == rp_r);
	wire              push  = in_s.valid && !full;
	wire              pop   = out_s.ready && !empty;

	assign in_s.ready  = !full;
	assign out_s.valid = !empty;
	assign out_s.data  = mem[rp_r[AW-1:0]];

	// Pointers advance on each handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (push) wp_r <= wp_r + 1'b1;
			if (pop) rp_r <= rp_r + 1'b1;
		end
	end

	// Storage needs no reset
	always_ff @(posedge aclk) begin
		if (push) mem[wp_r[AW-1:0]] <= in_s.data;
	end
endmodule // rsl_fifo

/* File: verification/rsl_link_chk.sv */
// Checker: port-level assertions for the serial slave link
`timescale 1ns/100ps
module rsl_link_chk
	import rsl_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        param_reset,
	input wire logic [6:0]  dip_sw,
	input wire logic        panel_run,
	input wire logic        term_run,
	input wire logic        run_cmd,
	input wire logic        serial_mode,
	input wire logic        line_rx,
	input wire logic        line_tx,
	input wire logic        line_oe,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp
);
	logic [17:0] quiet_cnt;  // Cycles since the host last pulled the line low
	logic        rx_seen;    // Host traffic since the last reply ended
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Quiet counter saturates so a long idle never wraps to a small value
	always_ff @(posedge aclk) begin
		if (!aresetn || (!line_rx && !line_oe))
			quiet_cnt <= '0;
		else if (quiet_cnt != 18'h3FFFF)
			quiet_cnt <= quiet_cnt + 18'h00001;
	end
	// Host activity flag, cleared once a reply releases the line
	always_ff @(posedge aclk) begin
		if (!aresetn || $fell(line_oe))
			rx_seen <= 1'b0;
		else if (!line_rx && !line_oe)
			rx_seen <= 1'b1;
	end
	a_mode_follows_sw: assert property (serial_mode == dip_sw[6])
		else $error("serial mode differs from switch seven");
	a_local_run_path: assert property (!dip_sw[6] |-> run_cmd == (panel_run | term_run))
		else $error("local run request not passed through");
	a_serial_ignores: assert property (dip_sw[6] && $past(dip_sw[6]) && !$past(s_axi_wvalid)
		&& !s_axi_bvalid && !$past(param_reset) |-> $stable(run_cmd))
		else $error("run output moved without a register write");
	a_quiet_before_tx: assert property ($rose(line_oe) |-> int'(quiet_cnt) >= WAIT_CYC)
		else $error("line driven before quiet time elapsed");
	a_reply_needs_cmd: assert property ($rose(line_oe) |-> rx_seen)
		else $error("line driven without a host message");
	a_start_bit_len: assert property (line_oe && $fell(line_tx) |=> !line_tx [*8])
		else $error("start bit too short");
	a_release_on_stop: assert property ($fell(line_oe) |-> $past(line_tx))
		else $error("line released outside stop level");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	a_read_answers: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	c_reply_sent: cover property ($rose(line_oe));
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	c_serial_run: cover property (serial_mode && run_cmd);
endmodule // rsl_link_chk

bind rsl_link rsl_link_chk u_chk (.aclk(aclk), .aresetn(aresetn), .param_reset(param_reset), .dip_sw(dip_sw),
	.panel_run(panel_run), .term_run(term_run), .run_cmd(run_cmd), .serial_mode(serial_mode),
	.line_rx(line_rx), .line_tx(line_tx), .line_oe(line_oe), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

/* File: verification/rsl_host.sv */
// Partner model: host controller on the shared serial pair
`timescale 1ns/100ps
module rsl_host
	import rsl_pkg::*;
(
	input  wire logic aclk,
	input  wire logic wire_lvl,
	output logic      host_tx,
	output logic      host_oe
);
	// Released at start; the pull-up sets the idle level
	initial begin
		host_tx = 1'b1;
		host_oe = 1'b0;
	end
	// Hex digit as an ASCII character
	function automatic logic [6:0] hex_ch(input logic [3:0] n);
		return (n < 4'hA) ? 7'h30 + n : 7'h37 + n;
	endfunction
	// One character: start, seven data LSB first, two stop
	task automatic send_char(input logic [6:0] c);
		logic [9:0] fr;
		fr = {2'b11, c, 1'b0};
		for (int i = 0; i < 10; i++) begin
			host_tx <= fr[i];
			repeat (BIT_CYC) @(posedge aclk);
		end
	endtask
	// Whole command after the quiet gap, then the line is let go
	task automatic send_msg(input logic [7:0] adr, input logic [7:0] cmd);
		logic [23:0] b;
		b = {adr, cmd, 8'h00 - adr - cmd};
		repeat (WAIT_CYC) @(posedge aclk);
		host_oe <= 1'b1;
		send_char(CH_COLON);
		for (int i = 2; i >= 0; i--) begin
			send_char(hex_ch(b[i*8+4 +: 4]));
			send_char(hex_ch(b[i*8 +: 4]));
		end
		send_char(CH_CR);
		send_char(CH_LF);
		host_oe <= 1'b0;
	endtask
	// Receive one reply character; ok stays low if none starts in time
	task automatic recv_char(output logic [6:0] c, output logic stop_ok, output logic ok);
		int n;
		n = 0;
		c = 7'h00;
		while (wire_lvl && n < 400000) begin
			@(posedge aclk);
			n++;
		end
		ok = !wire_lvl;
		repeat (HALF_CYC) @(posedge aclk);
		for (int i = 0; i < 7; i++) begin
			repeat (BIT_CYC) @(posedge aclk);
			c[i] = wire_lvl;
		end
		repeat (BIT_CYC) @(posedge aclk);
		stop_ok = wire_lvl;
	endtask
endmodule // rsl_host

/* File: verification/tb.sv */
// Testbench: serial slave link against the host model and a register master
`timescale 1ns/100ps
module tb
	import rsl_pkg::*;
;
	localparam int LIM = 400000;  // Longest legal wait, a stalled write included
	logic        aclk, aresetn, por_done, param_reset, panel_run, term_run;
	logic [6:0]  dip_sw, ch;
	logic        run_cmd, serial_mode, line_rx, line_tx, line_oe, host_tx, host_oe, ok, st;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rs;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [5:0]  adr;       // Station address chosen for this run
	int          error_cnt, n_checks, oe_cnt, c0;
	// Shared pair: whoever enables drives, else the bias pulls it high
	assign line_rx = line_oe ? line_tx : (host_oe ? host_tx : 1'b1);
	always #25 aclk = ~aclk;
	// Cycles the device has driven the pair
	always @(posedge aclk) oe_cnt <= oe_cnt + 32'(line_oe);
	rsl_link DUT (.aclk(aclk), .aresetn(aresetn), .por_done(por_done), .param_reset(param_reset),
		.dip_sw(dip_sw), .panel_run(panel_run), .term_run(term_run), .run_cmd(run_cmd),
		.serial_mode(serial_mode), .line_rx(line_rx), .line_tx(line_tx), .line_oe(line_oe),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	rsl_host host (.aclk(aclk), .wire_lvl(line_rx), .host_tx(host_tx), .host_oe(host_oe));
	// Verdict and end of run
	task automatic print_verdict();
		if (error_cnt == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// A wait that ran out counts as a mismatch
	task automatic timeout();
		error_cnt++;
		print_verdict();
	endtask
	task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// Register write; address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < LIM; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == LIM) timeout();
		r = bresp;
		bready <= 1'b0;
	endtask
	// Register read
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < LIM; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == LIM) timeout();
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// Main sequence
	initial begin
		{aclk, aresetn, por_done, param_reset, panel_run, term_run} = '0;
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		{dip_sw, error_cnt, n_checks, oe_cnt} = '0;
		wstrb = 4'hF;
		void'($urandom(32'h346647B2));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		// Shipped state: every switch off, run follows panel and terminals
		for (int i = 0; i < 6; i++) begin
			@(posedge aclk);
			{panel_run, term_run} <= 2'($urandom);
			@(negedge aclk);
			chk_word({31'h0, panel_run | term_run}, {30'h0, serial_mode, run_cmd});
		end
		adr = 6'($urandom_range(63, 1));
		@(posedge aclk);
		dip_sw <= {1'b1, adr};
		@(posedge aclk);
		por_done <= 1'b1;
		@(posedge aclk);
		dip_sw[5:0] <= ~adr;
		// A switch change after power-up must not alter the address
		axi_rd(REG_STATUS, rd, rs);
		chk_word({26'h0, adr}, {26'h0, rd[9:4]});
		chk_word(32'h1, {31'h0, rd[18]});
		// Serial mode: every local combination is ignored
		axi_wr(REG_CTRL, 32'h1, rs);
		for (int i = 0; i < 4; i++) begin
			@(posedge aclk);
			{panel_run, term_run} <= 2'(i);
			@(negedge aclk);
			chk_word(32'h1, {31'h0, run_cmd});
		end
		axi_wr(REG_CTRL, 32'h0, rs);
		@(negedge aclk);
		chk_word(32'h0, {31'h0, run_cmd});
		axi_rd(8'h3C, rd, rs);
		chk_word({30'h0, RESP_SLVERR}, {30'h0, rs});
		// Reply waits in a full FIFO; nothing may go out unasked
		for (int i = 0; i < 4; i++) axi_wr(REG_TXDATA, 32'(32'h41 + i), rs);
		c0 = oe_cnt;
		host.send_msg({2'b00, 6'(adr % 63 + 1)}, CMD_WRITE);
		axi_rd(REG_RXERR, rd, rs);
		chk_word(32'h1, rd);
		host.send_msg({2'b00, adr}, CMD_READ);
		chk_word(32'(c0), 32'(oe_cnt));
		axi_rd(REG_RXCMD, rd, rs);
		chk_word({24'h0, CMD_READ}, {24'h0, rd[7:0]});
		// Terminator write stalls until the FIFO frees a slot
		fork
			axi_wr(REG_TXDATA, {25'h0, CH_LF}, rs);
			for (int i = 0; i < 5; i++) begin
				host.recv_char(ch, st, ok);
				chk_word({25'h0, (i < 4) ? 7'(7'h41 + i) : CH_LF}, {25'h0, ch});
				chk_word(32'h3, {30'h0, st, ok});
			end
		join
		chk_word({30'h0, RESP_OKAY}, {30'h0, rs});
		repeat (3 * BIT_CYC) @(posedge aclk);
		chk_word(32'h0, {31'h0, line_oe});
		// Leaving serial mode stores the address; a parameter reset keeps it
		@(posedge aclk);
		dip_sw[6] <= 1'b0;
		axi_rd(REG_STATUS, rd, rs);
		chk_word({26'h0, adr}, {26'h0, rd[17:12]});
		@(posedge aclk);
		param_reset <= 1'b1;
		@(posedge aclk);
		param_reset <= 1'b0;
		axi_rd(REG_STATUS, rd, rs);
		chk_word({26'h0, adr}, {26'h0, rd[17:12]});
		print_verdict();
	end
endmodule // tb
